// ### hw/cwcs_top.sv
// Configuration word decode, reset delay sequence and dual speed oscillator.
// Assumes synchronous pin inputs, a programmed word on config_fuses and an APB master.
//
// What this block does
// - Programmed bit reads zero, word outside program space.
// - All code protect bits one means unprotected.
// - Trip select field picks brownout trip voltage.
// - Bit six enables brownout reset.
// - Bit five selects reset pin or input.
// - Bit four low enables power-up delay.
// - Brownout always forces the power-up delay.
// - Bit three alone enables the watchdog.
// - Three-bit field decodes eight oscillator modes.
// - External clock mode frees the output pin.
// - Resistor oscillator stopped during any reset.
// - Internal 4 MHz oscillator stopped during reset.
// - Clock output runs at oscillator divided by four.
// - Clock output held low during reset.
// - Speed bit switches normal and slow rate.
// - Slow rate is fixed near 37 kHz.
// - Fast to slow stalls processor 100-300 us.
// - Slow to fast stalls processor 1.25-3.25 us.
// - Speed bit ignored outside RC modes.
// - Crystal modes wait 1024 crystal cycles.
`timescale 1ns/1ps
module cwcs_top #(
    parameter int POWERUP_CYCLES = cwcs_pkg::POWERUP_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [13:0] config_fuses,
    input wire logic por_pulse,
    input wire logic brownout_low,
    input wire logic wake_pulse,
    input wire logic crystal_tick,
    input wire logic port_a_bit5_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic code_protect_bits,
    output logic [1:0] brownout_trip_select,
    output logic brownout_reset_enable,
    output logic watchdog_enable,
    output logic master_clear_input,
    output logic port_a_bit5_data,
    output logic device_in_reset,
    output logic cpu_stall,
    output logic osc_running,
    output logic osc_tick,
    output logic crystal_out_pin_o,
    output logic crystal_out_pin_oe,
    output logic port_a_bit6_gpio,
    output logic port_a_bit7_gpio,
    output logic clock_from_input_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration latch and decode.

    logic cfg_valid_q;
    cwcs_pkg::cwcs_cfg_t cfg_q;
    cwcs_pkg::cwcs_cfg_t cfg_d;
    logic [13:0] word_q;
    logic crystal_mode;
    logic dual_mode;
    logic quarter_clock_output_mode;

    // Fuse bits read zero when programmed, so fields are taken as stored.
    // A mixed set of protect bits counts as protected.
    // That is the safe reading of a partly programmed part.
    // Protection stays on until software-visible state is known.
    always_comb begin
        cfg_d.code_protect = ~&{config_fuses[cwcs_pkg::POS_CP_HI +: 2],
                               config_fuses[cwcs_pkg::POS_CP_LO +: 2]};
        cfg_d.trip_select = config_fuses[cwcs_pkg::POS_TRIP +: 2];
        cfg_d.bor_enable = config_fuses[cwcs_pkg::POS_BOR_EN];
        cfg_d.reset_pin_is_master_clear_input = config_fuses[cwcs_pkg::POS_MASTER_CLEAR_INPUT_FN];
        cfg_d.powerup_delay_enable_n = config_fuses[cwcs_pkg::POS_POWERUP_DELAY_TIMER_N];
        cfg_d.watchdog_enable = config_fuses[cwcs_pkg::POS_WDT_EN];
        cfg_d.osc_mode = cwcs_pkg::cwcs_osc_mode_t'(config_fuses[cwcs_pkg::POS_OSC +: 3]);
    end

    // The word is caught once after reset release and then frozen.
    // Sampling it once keeps a later upset on the fuse lines
    // from changing modes under running code.
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_valid_q <= 1'b0;
            cfg_q <= '0;
            word_q <= '0;
        end else if (!cfg_valid_q) begin
            cfg_valid_q <= 1'b1;
            cfg_q <= cfg_d;
            word_q <= config_fuses | (14'h0001 << cwcs_pkg::POS_UNIMPL);
        end
    end

    // Mode groups derived from the oscillator field.
    // Codes four to seven are the on-chip RC sources with a speed bit.
    // The odd codes among them also drive the quarter clock pin.
    always_comb begin
        crystal_mode = cfg_q.osc_mode inside {cwcs_pkg::OSC_LOW_POWER_CRYSTAL,
            cwcs_pkg::OSC_STANDARD_CRYSTAL, cwcs_pkg::OSC_HIGH_SPEED_CRYSTAL};
        dual_mode = cfg_q.osc_mode[2];
        quarter_clock_output_mode = cfg_q.osc_mode[2] & cfg_q.osc_mode[0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset delay sequence.

    cwcs_pkg::cwcs_seq_t seq_q;
    logic [23:0] delay_cnt_q;
    logic [10:0] xtal_cnt_q;
    logic armed_q;
    logic master_clear_input_low;
    logic any_reset;

    // The reset pin counts only when set up as master clear.
    // Any reset stops the RC oscillators and holds the processor.
    // The clock pin is forced low for as long as it lasts.
    assign master_clear_input_low = cfg_q.reset_pin_is_master_clear_input & ~port_a_bit5_pin;
    assign any_reset = srst | ~cfg_valid_q | (seq_q != cwcs_pkg::SEQ_RUN) | master_clear_input_low;

    // Brownout holds the part, then the power-up delay runs whatever bit four says.
    // A new brownout during the delay restarts it from the full count.
    // A power-on pulse rearms the sequence, so bit four is read afresh.
    // A wake pulse reruns only the crystal count.
    always_ff @(posedge clock) begin
        if (srst) begin
            seq_q <= cwcs_pkg::SEQ_POWERUP;
            delay_cnt_q <= '0;
            xtal_cnt_q <= '0;
            armed_q <= 1'b0;
        end else if (!cfg_valid_q) begin
            armed_q <= 1'b0;
        end else if (cfg_q.bor_enable && brownout_low) begin
            seq_q <= cwcs_pkg::SEQ_BROWNOUT;
            armed_q <= 1'b0;
        end else if (por_pulse) begin
            seq_q <= cwcs_pkg::SEQ_POWERUP;
            armed_q <= 1'b0;
        end else begin
            unique case (seq_q)
                cwcs_pkg::SEQ_BROWNOUT: begin
                    seq_q <= cwcs_pkg::SEQ_POWERUP;
                    delay_cnt_q <= 24'(POWERUP_CYCLES);
                    armed_q <= 1'b1;
                end
                cwcs_pkg::SEQ_POWERUP: begin
                    if (!armed_q) begin
                        armed_q <= 1'b1;
                        delay_cnt_q <= cfg_q.powerup_delay_enable_n ? 24'h000000 : 24'(POWERUP_CYCLES);
                    end else if (delay_cnt_q != 24'h000000) begin
                        delay_cnt_q <= delay_cnt_q - 24'h000001;
                    end else if (crystal_mode) begin
                        seq_q <= cwcs_pkg::SEQ_STARTUP;
                        xtal_cnt_q <= 11'(cwcs_pkg::XTAL_STARTUP_TICKS);
                    end else begin
                        seq_q <= cwcs_pkg::SEQ_RUN;
                    end
                end
                cwcs_pkg::SEQ_STARTUP: begin
                    if (xtal_cnt_q == 11'h000) begin
                        seq_q <= cwcs_pkg::SEQ_RUN;
                    end else if (crystal_tick) begin
                        xtal_cnt_q <= xtal_cnt_q - 11'h001;
                    end
                end
                cwcs_pkg::SEQ_RUN: begin
                    if (wake_pulse && crystal_mode) begin
                        seq_q <= cwcs_pkg::SEQ_STARTUP;
                        xtal_cnt_q <= 11'(cwcs_pkg::XTAL_STARTUP_TICKS);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Speed control and processor stall.

    logic speed_req_q;
    logic slow_active_q;
    logic [11:0] stall_cnt_q;
    logic want_slow;

    assign want_slow = speed_req_q & dual_mode;

    // A change of effective speed starts the stall window for its direction.
    // Each window uses the short end of its range, so code resumes early.
    // A speed bit set outside the RC modes never gets here.
    // The mode mask on want_slow keeps it out.
    always_ff @(posedge clock) begin
        if (srst) begin
            slow_active_q <= 1'b0;
            stall_cnt_q <= '0;
        end else if (want_slow != slow_active_q) begin
            slow_active_q <= want_slow;
            stall_cnt_q <= want_slow ? 12'(cwcs_pkg::STALL_TO_SLOW_CYC) : 12'(cwcs_pkg::STALL_TO_FAST_CYC);
        end else if (stall_cnt_q != 12'h000) begin
            stall_cnt_q <= stall_cnt_q - 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator model and quarter clock output.

    logic [9:0] osc_div_q;
    logic [1:0] quarter_q;
    logic osc_wrap;

    // The wrap test is greater-or-equal on purpose.
    // After a slow to fast switch the divider may stand above the fast limit.
    // An equality test would then run it on to its own overflow.
    assign osc_wrap = osc_div_q >= (slow_active_q ? 10'(cwcs_pkg::SLOW_DIV - 1) : 10'(cwcs_pkg::FAST_DIV - 1));

    // Only the RC style modes run here, and they stop while any reset is active.
    // Clearing the divider in reset makes the first period after release whole.
    // Crystal and external sources show no ticks here.
    always_ff @(posedge clock) begin
        if (srst || any_reset || !dual_mode) begin
            osc_div_q <= '0;
            osc_tick <= 1'b0;
            quarter_q <= '0;
        end else begin
            osc_div_q <= osc_wrap ? 10'h000 : osc_div_q + 10'h001;
            osc_tick <= osc_wrap;
            if (osc_wrap) begin
                quarter_q <= quarter_q + 2'h1;
            end
        end
    end

    // Pin ownership and status outputs, all registered.
    // The clock pin enable follows the mode even in reset.
    // The pin is then driven low rather than left floating.
    always_ff @(posedge clock) begin
        if (srst) begin
            crystal_out_pin_o <= 1'b0;
            crystal_out_pin_oe <= 1'b0;
            port_a_bit6_gpio <= 1'b0;
            port_a_bit7_gpio <= 1'b0;
            clock_from_input_pin <= 1'b0;
            osc_running <= 1'b0;
            device_in_reset <= 1'b1;
            cpu_stall <= 1'b0;
        end else begin
            crystal_out_pin_o <= quarter_clock_output_mode & ~any_reset & quarter_q[1];
            crystal_out_pin_oe <= quarter_clock_output_mode;
            port_a_bit6_gpio <= ~crystal_mode & ~quarter_clock_output_mode;
            port_a_bit7_gpio <= cfg_q.osc_mode inside {cwcs_pkg::OSC_INTERNAL_RC, cwcs_pkg::OSC_INTERNAL_RC_QUARTER_CLOCK_OUTPUT};
            clock_from_input_pin <= cfg_q.osc_mode == cwcs_pkg::OSC_EXTERNAL_CLOCK;
            osc_running <= dual_mode & ~any_reset;
            device_in_reset <= any_reset;
            cpu_stall <= (want_slow != slow_active_q) || (stall_cnt_q > 12'h001);
        end
    end

    // Configuration outputs taken from the frozen copy.
    // Until the word is latched, protection reads as on.
    // Nothing can read program memory right after reset.
    always_ff @(posedge clock) begin
        if (srst) begin
            code_protect_bits <= 1'b1;
            brownout_trip_select <= '0;
            brownout_reset_enable <= 1'b0;
            watchdog_enable <= 1'b0;
            master_clear_input <= 1'b1;
            port_a_bit5_data <= 1'b0;
        end else begin
            code_protect_bits <= cfg_q.code_protect | ~cfg_valid_q;
            brownout_trip_select <= cfg_q.trip_select;
            brownout_reset_enable <= cfg_q.bor_enable;
            watchdog_enable <= cfg_q.watchdog_enable;
            master_clear_input <= ~master_clear_input_low;
            port_a_bit5_data <= cfg_q.reset_pin_is_master_clear_input ? 1'b0 : port_a_bit5_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access phase, writes to the word are ignored.

    logic setup;
    logic [15:0] idx;
    logic hit;
    logic [31:0] rd_d;

    assign setup = psel & ~penable;
    assign idx = {2'b00, paddr[15:2]};

    // Read mux for the three registers.
    // Unaligned or unmapped addresses give an error and zero data.
    // Writes to the word or the status register are taken and dropped.
    // The fuse image can never be altered over the bus.
    always_comb begin
        hit = 1'b1;
        rd_d = '0;
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (idx == cwcs_pkg::IDX_CONFIG) begin
            rd_d = {18'h00000, word_q};
        end else if (idx == cwcs_pkg::IDX_POWER_CTRL) begin
            rd_d = 32'(speed_req_q) << cwcs_pkg::POS_SPEED;
        end else if (idx == cwcs_pkg::IDX_STATUS) begin
            rd_d = {26'h0000000, slow_active_q, cpu_stall, osc_running, device_in_reset, seq_q};
        end else begin
            hit = 1'b0;
        end
    end

    // Answer is prepared in the setup cycle and stands for the access cycle.
    // This gives zero wait states, with pready high for one cycle.
    // Read data is zero in write cycles, so no stale word lingers.
    always_ff @(posedge clock) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            prdata <= (setup && !pwrite) ? rd_d : 32'h00000000;
            pslverr <= setup & ~hit;
        end
    end

    // Speed bit write takes effect at the completing edge only.
    // A refused access leaves the speed bit untouched.
    // The bit is kept in every mode but acts only in the RC modes.
    always_ff @(posedge clock) begin
        if (srst) begin
            speed_req_q <= cwcs_pkg::SPEED_RESET;
        end else if (psel && penable && pready && pwrite && !pslverr && idx == cwcs_pkg::IDX_POWER_CTRL) begin
            speed_req_q <= pwdata[cwcs_pkg::POS_SPEED];
        end
    end

endmodule

// ### hw/cwcs_pkg.sv
// Package for the configuration word and clock select block.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
package cwcs_pkg;

    // Clock rate of the block in kHz.
    localparam int CLK_KHZ = 25000;

    // Register indexes; byte address is four times the index.
    localparam logic [15:0] IDX_CONFIG = 16'h2007;
    localparam logic [15:0] IDX_POWER_CTRL = 16'h0010;
    localparam logic [15:0] IDX_STATUS = 16'h0011;

    // Configuration word field positions.
    localparam int CFG_W = 14;
    localparam int POS_CP_HI = 12;
    localparam int POS_TRIP = 10;
    localparam int POS_CP_LO = 8;
    localparam int POS_UNIMPL = 7;
    localparam int POS_BOR_EN = 6;
    localparam int POS_MASTER_CLEAR_INPUT_FN = 5;
    localparam int POS_POWERUP_DELAY_TIMER_N = 4;
    localparam int POS_WDT_EN = 3;
    localparam int POS_OSC = 0;

    // Speed bit position in the power control register and its reset value.
    localparam int POS_SPEED = 3;
    localparam logic SPEED_RESET = 1'b0;

    // Oscillator rates in kHz, nominal.
    localparam int FAST_KHZ = 4000;
    localparam int SLOW_KHZ = 37;
    localparam int FAST_DIV = CLK_KHZ / FAST_KHZ;
    localparam int SLOW_DIV = CLK_KHZ / SLOW_KHZ;

    // Stall windows in ns (least figures) and their cycle counts, rounded up.
    localparam int STALL_TO_SLOW_NS = 100000;
    localparam int STALL_TO_FAST_NS = 1250;
    localparam int STALL_TO_SLOW_CYC = (STALL_TO_SLOW_NS * (CLK_KHZ / 1000) + 999) / 1000;
    localparam int STALL_TO_FAST_CYC = (STALL_TO_FAST_NS * (CLK_KHZ / 1000) + 999) / 1000;

    // Power-up delay in us and crystal startup length in crystal cycles.
    localparam int POWERUP_US = 72000;
    localparam int POWERUP_CYC = POWERUP_US * (CLK_KHZ / 1000);
    localparam int XTAL_STARTUP_TICKS = 1024;

    // Oscillator modes as coded in the configuration word.
    typedef enum logic [2:0] {
        OSC_LOW_POWER_CRYSTAL = 3'h0,
        OSC_STANDARD_CRYSTAL = 3'h1,
        OSC_HIGH_SPEED_CRYSTAL = 3'h2,
        OSC_EXTERNAL_CLOCK = 3'h3,
        OSC_INTERNAL_RC = 3'h4,
        OSC_INTERNAL_RC_QUARTER_CLOCK_OUTPUT = 3'h5,
        OSC_RESISTOR = 3'h6,
        OSC_RESISTOR_QUARTER_CLOCK_OUTPUT = 3'h7
    } cwcs_osc_mode_t;

    // Decoded configuration carried as one group.
    typedef struct packed {
        logic code_protect;
        logic [1:0] trip_select;
        logic bor_enable;
        logic reset_pin_is_master_clear_input;
        logic powerup_delay_enable_n;
        logic watchdog_enable;
        cwcs_osc_mode_t osc_mode;
    } cwcs_cfg_t;

    // Reset sequence states, Gray coded along the crystal power-up path.
    typedef enum logic [1:0] {
        SEQ_POWERUP = 2'b00,
        SEQ_STARTUP = 2'b01,
        SEQ_RUN = 2'b11,
        SEQ_BROWNOUT = 2'b10
    } cwcs_seq_t;

endpackage

// ### verification/cwcs_properties.sv
// Concurrent checks on the configuration and clock select block.
// Assumes it is bound into cwcs_top and sees only that module's ports.
`timescale 1ns/1ps
module cwcs_properties (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic port_a_bit5_pin,
    input wire logic code_protect_bits,
    input wire logic [1:0] brownout_trip_select,
    input wire logic brownout_reset_enable,
    input wire logic watchdog_enable,
    input wire logic master_clear_input,
    input wire logic device_in_reset,
    input wire logic cpu_stall,
    input wire logic osc_running,
    input wire logic osc_tick,
    input wire logic crystal_out_pin_o,
    input wire logic crystal_out_pin_oe,
    input wire logic port_a_bit6_gpio,
    input wire logic port_a_bit7_gpio,
    input wire logic clock_from_input_pin
);
    logic [1:0] settle_q;
    logic [12:0] stall_q;

    // Counts edges after reset release so the latched word has settled.
    always_ff @(posedge clock) begin
        if (srst) begin
            settle_q <= 2'h0;
        end else if (settle_q != 2'h3) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // Measures the current processor stall in cycles.
    always_ff @(posedge clock) begin
        stall_q <= cpu_stall ? stall_q + 13'h1 : 13'h0;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // An APB setup cycle, and a reset that has lasted two edges.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_held_reset;
        device_in_reset && $past(device_in_reset);
    endsequence

    ////////////////////////////////////////////////////////////
    a_apb_answer: assert property (s_setup |=> pready)
        else $error("No answer in the access cycle.");
    a_ready_once: assert property (pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    a_cfg_stable: assert property (settle_q == 2'h3 |-> $stable({code_protect_bits, brownout_trip_select,
        brownout_reset_enable, watchdog_enable})) else $error("Latched configuration changed.");
    a_osc_stop: assert property (s_held_reset |-> !osc_running)
        else $error("Oscillator runs during reset.");
    a_quarter_clock_output_low: assert property (s_held_reset |-> !crystal_out_pin_o)
        else $error("Clock output not low during reset.");
    a_tick_gap: assert property (osc_tick |=> !osc_tick [*5])
        else $error("Oscillator ticks too close.");
    a_stall_span: assert property ($fell(cpu_stall) |-> (stall_q >= 13'h20 && stall_q <= 13'h51)
        || (stall_q >= 13'h9C4 && stall_q <= 13'h1D4C)) else $error("Stall length out of range.");
    a_ext_pins: assert property (settle_q == 2'h3 && clock_from_input_pin |-> port_a_bit6_gpio
        && !port_a_bit7_gpio && !crystal_out_pin_oe) else $error("External clock pins wrong.");
    a_pin_reset: assert property (!master_clear_input |-> !$past(port_a_bit5_pin))
        else $error("Master clear without a low pin.");
    a_quarter_clock_output_pin: assert property (crystal_out_pin_oe |-> !port_a_bit6_gpio)
        else $error("Clock output pin also free.");
endmodule

bind cwcs_top cwcs_properties u_props (
    .clock, .srst, .psel, .penable, .pready, .port_a_bit5_pin, .code_protect_bits,
    .brownout_trip_select, .brownout_reset_enable, .watchdog_enable, .master_clear_input,
    .device_in_reset, .cpu_stall, .osc_running, .osc_tick, .crystal_out_pin_o,
    .crystal_out_pin_oe, .port_a_bit6_gpio, .port_a_bit7_gpio, .clock_from_input_pin
);

// ### verification/cwcs_tb.sv
// Self-checking bench for the configuration and clock select block.
// Assumes one APB access cycle and a shortened power-up delay.
`timescale 1ns/1ps
module tb;
    localparam int PU = 20;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic [13:0] config_fuses = 14'h3FFF;
    logic por_pulse = 1'h0;
    logic brownout_low = 1'h0;
    logic wake_pulse = 1'h0;
    logic crystal_tick = 1'h0;
    logic port_a_bit5_pin = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [1:0] brownout_trip_select;
    logic pready, pslverr, er, code_protect_bits, brownout_reset_enable, watchdog_enable, osc_tick;
    logic master_clear_input, port_a_bit5_data, device_in_reset, cpu_stall, osc_running;
    logic crystal_out_pin_o, crystal_out_pin_oe, port_a_bit6_gpio, port_a_bit7_gpio, clock_from_input_pin;
    int mismatches = 0;
    int comparisons = 0;
    int n;

    cwcs_top #(.POWERUP_CYCLES(PU)) u_dut (
        .clock, .srst, .config_fuses, .por_pulse, .brownout_low, .wake_pulse, .crystal_tick,
        .port_a_bit5_pin, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .code_protect_bits, .brownout_trip_select, .brownout_reset_enable, .watchdog_enable,
        .master_clear_input, .port_a_bit5_data, .device_in_reset, .cpu_stall, .osc_running,
        .osc_tick, .crystal_out_pin_o, .crystal_out_pin_oe, .port_a_bit6_gpio, .port_a_bit7_gpio,
        .clock_from_input_pin
    );

    // Clock at 25 MHz and a crystal tick on every other edge.
    always #20 clock = ~clock;
    always @(posedge clock) crystal_tick <= ~crystal_tick;

    ////////////////////////////////////////////////////////////
    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Resets the block with a given programmed word.
    task automatic boot(input logic [13:0] f);
        @(posedge clock);
        config_fuses <= f;
        srst <= 1'h1;
        repeat (2) @(posedge clock);
        srst <= 1'h0;
        repeat (3) @(negedge clock);
    endtask

    // Gives a power-on or wake pulse of one cycle.
    task automatic kick(input logic p, input logic w);
        @(posedge clock);
        por_pulse <= p;
        wake_pulse <= w;
        @(posedge clock);
        por_pulse <= 1'h0;
        wake_pulse <= 1'h0;
        repeat (3) @(negedge clock);
    endtask

    // Counts cycles until the device leaves reset.
    task automatic wait_run();
        n = 0;
        while (device_in_reset !== 1'h0 && n < 9000) begin
            @(negedge clock);
            n++;
        end
    endtask

    // Counts cycles of a processor stall that follows a speed write.
    task automatic stall();
        n = 0;
        repeat (2) @(negedge clock);
        while (cpu_stall === 1'h1 && n < 9000) begin
            @(negedge clock);
            n++;
        end
    endtask

    // Measures one period of the oscillator tick or the clock output.
    task automatic period(input bit c);
        int k;
        n = 0;
        for (int i = 0; i < 4; i++) begin
            k = 0;
            while ((c ? crystal_out_pin_o : osc_tick) !== i[0] && k < 2000) begin
                @(negedge clock);
                k++;
            end
            if (i > 1) n += k;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // Cuts a hang short.
    initial begin
        repeat (80000) @(posedge clock);
        mismatches++;
        give_verdict();
    end

    // Main sequence: internal RC with output, then every oscillator mode.
    initial begin
        boot(14'h3F7D);
        wait_run();
        chk({code_protect_bits, brownout_trip_select, brownout_reset_enable, watchdog_enable}, 32'hF);
        chk({crystal_out_pin_oe, port_a_bit6_gpio, port_a_bit7_gpio, clock_from_input_pin,
            osc_running, master_clear_input}, 32'h2B);
        apb(1'h0, 16'h801C, 32'h0);
        chk(rd, 32'h3FFD);
        apb(1'h1, 16'h801C, 32'h0);
        apb(1'h0, 16'h801C, 32'h0);
        chk(rd, 32'h3FFD);
        apb(1'h0, 16'h0100, 32'h0);
        chk(rd, 32'h00000000);
        chk(32'(er), 32'h00000001);
        period(1'h1);
        chk(n, 32'h18);
        @(posedge clock);
        port_a_bit5_pin <= 1'h0;
        repeat (3) @(negedge clock);
        chk({master_clear_input, device_in_reset}, 32'h1);
        @(posedge clock);
        port_a_bit5_pin <= 1'h1;
        wait_run();
        apb(1'h1, 16'h0040, 32'h8);
        stall();
        chk(n > 2450 && n <= 7500, 32'h1);
        apb(1'h0, 16'h0040, 32'h0);
        chk(rd, 32'h8);
        period(1'h0);
        chk(n, 32'h2A3);
        apb(1'h1, 16'h0040, 32'h0);
        stall();
        chk(n >= 28 && n <= 81, 32'h1);
        period(1'h0);
        chk(n, 32'h6);
        @(posedge clock);
        brownout_low <= 1'h1;
        repeat (5) @(posedge clock);
        brownout_low <= 1'h0;
        repeat (2) @(negedge clock);
        wait_run();
        chk(n >= PU - 3 && n < PU + 10, 32'h1);
        $display("test rc done");
        for (int m = 0; m < 8; m++) begin
            boot({2'h3, m[1:0], 2'h2, 5'h10, m[2:0]});
            chk({code_protect_bits, brownout_trip_select, brownout_reset_enable, watchdog_enable},
                {1'h1, m[1:0], 2'h0});
            chk({crystal_out_pin_oe, port_a_bit6_gpio, port_a_bit7_gpio, clock_from_input_pin},
                {m == 5 || m == 7, m == 3 || m == 4 || m == 6, m == 4 || m == 5, m == 3});
            wait_run();
            chk(m < 3 ? n >= 2048 && n < 2200 : n >= PU - 4 && n < PU + 10, 32'h1);
            chk({osc_running, master_clear_input}, {m > 3, 1'h1});
            @(posedge clock);
            port_a_bit5_pin <= 1'h0;
            brownout_low <= 1'h1;
            repeat (3) @(negedge clock);
            chk({port_a_bit5_data, master_clear_input, device_in_reset}, 32'h2);
            @(posedge clock);
            port_a_bit5_pin <= 1'h1;
            brownout_low <= 1'h0;
            apb(1'h1, 16'h0040, 32'h8);
            stall();
            chk(m > 3 ? n > 2450 : n == 0, 32'h1);
            kick(1'h1, 1'h0);
            wait_run();
            chk(m < 3 ? n >= 2040 && n < 2200 : n >= PU - 4 && n < PU + 10, 32'h1);
            kick(1'h0, 1'h1);
            wait_run();
            chk(m < 3 ? n >= 2000 : n == 0, 32'h1);
        end
        $display("test modes done");
        give_verdict();
    end
endmodule
